/* File: include/acl_staging_params.svh */
`ifndef ACL_STAGING_PARAMS_SVH
`define ACL_STAGING_PARAMS_SVH

// Register offsets
`define ACL_OFF_STAGE_BASE 16'h0600
`define ACL_OFF_MAC_31_24 16'h0604
`define ACL_OFF_MAC_23_16 16'h0605
`define ACL_OFF_MAC_15_8 16'h0606
`define ACL_OFF_MAC_7_0 16'h0607
`define ACL_OFF_ETYPE_HIGH 16'h0608
`define ACL_OFF_ETYPE_LOW 16'h0609
`define ACL_OFF_PRIO_ACTION 16'h060a
`define ACL_OFF_REMARK_MAP 16'h060b
`define ACL_OFF_SPARE 16'h060c
`define ACL_OFF_FWD_MAP 16'h060d
`define ACL_OFF_RULESET_HIGH 16'h060e
`define ACL_OFF_RULESET_LOW 16'h060f
`define ACL_OFF_SEL_HIGH 16'h0610
`define ACL_OFF_SEL_LOW 16'h0611

// Reset values
`define ACL_RESET_BYTE 8'h00
`define ACL_RESET_DONE 1'b1

// Staging bytes handled outside this block
`define ACL_EXT_BYTES 4

// Priority action byte fields
`define ACL_PRIO_MODE_MSB 7
`define ACL_PRIO_MODE_LSB 6
`define ACL_PRIO_MSB 5
`define ACL_PRIO_LSB 3
`define ACL_REMARK_EN_BIT 2
`define ACL_REMARK_HI_MSB 1
`define ACL_REMARK_HI_LSB 0

// Remark / map mode byte fields
`define ACL_REMARK_LO_BIT 7
`define ACL_MAP_MODE_MSB 6
`define ACL_MAP_MODE_LSB 5

// Forward map byte fields
`define ACL_FWD_P1_P4_MSB 3
`define ACL_FWD_P5_BIT 6

// Table size
`define ACL_TABLE_DEPTH 16
`define ACL_INDEX_W 4

`endif

/* File: include/acl_staging_pkg.sv */
package acl_staging_pkg;

  typedef logic [7:0] byte_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WRITE,
    ST_READ,
    ST_LOAD
  } xfer_state_t;

endpackage : acl_staging_pkg

/* File: rtl/acl_table_mem.sv */
module acl_table_mem
  import acl_staging_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int IDX_W = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Access
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [IDX_W-1:0] index,
  input wire logic [15:0] byte_wr_en,
  input wire logic [127:0] wdata,
  output logic [127:0] rdata
);

  byte_t mem [0:DEPTH-1][0:15];

  // No reset on the array: it is large and software rewrites entries
  always_ff @(posedge clk) begin
    if (wr_en) begin
      for (int k = 0; k < 16; k++) begin
        if (byte_wr_en[k]) begin
          mem[index][k] <= wdata[8*k +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else if (rd_en) begin
      for (int k = 0; k < 16; k++) begin
        rdata[8*k +: 8] <= mem[index][k];
      end
    end
  end

endmodule : acl_table_mem

/* File: rtl/acl_entry_staging_regs.sv */
`include "acl_staging_params.svh"

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - A write to the low byte-select register while idle starts a transfer of enabled bytes.
// - High select bit 0 picks offset 7, up to bit 7 picking offset 0.
// - Low select bit 0 picks offset 15, up to bit 7 picking offset 8.
// - A set select bit includes its byte; a clear bit leaves it out.
// - Forward map bits 0-3 enable ports 1-4, bit 6 enables port 5.
// - Remark priority bits 2:1 sit in bits 1:0 of offset ten.
// - Remark priority bit 0 is bit 7 of offset eleven; map mode bits 6:5.
// - Offset ten: priority mode 7:6, priority 5:3, remark enable bit 2.
// - Read status clears on read start and sets once results are loaded.
// - Direction input: one writes the indexed entry, zero reads it.
////////////////////////////////////////////////////////////////////////////////

module acl_entry_staging_regs
  import acl_staging_pkg::*;
#(
  parameter int TABLE_DEPTH = `ACL_TABLE_DEPTH,
  parameter int INDEX_W = `ACL_INDEX_W
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // Register port
  input wire logic [15:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // Access control from the neighbouring control register
  input wire logic ACCESS_WRITE,
  input wire logic [INDEX_W-1:0] ACCESS_INDEX,
  output logic READ_DONE,
  output logic WRITE_DONE,
  output logic TRANSFER_BUSY,
  // Staging bytes 0..3 kept in the neighbouring block
  input wire logic [31:0] LOW_STAGE_DATA,
  output logic [3:0] LOW_STAGE_LOAD,
  output logic [31:0] LOW_STAGE_RESULT,
  // Staged fields
  output logic [31:0] MAC_LOW,
  output logic [15:0] ETHERTYPE,
  output logic [1:0] PRIORITY_SELECT_MODE,
  output logic [2:0] PRIORITY,
  output logic REMARK_ENABLE_FLAG,
  output logic [2:0] REMARK_PRIORITY,
  output logic [1:0] FORWARD_MAP_MODE,
  output logic [4:0] FORWARD_PORTS,
  output logic [15:0] RULESET
);

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Maps a register address to a staging byte number 4..15
  function automatic logic [4:0] stage_lookup(input logic [15:0] addr);
    logic [4:0] res;
    res = 5'h00;
    unique case (addr)
      `ACL_OFF_MAC_31_24: res = 5'h14;
      `ACL_OFF_MAC_23_16: res = 5'h15;
      `ACL_OFF_MAC_15_8: res = 5'h16;
      `ACL_OFF_MAC_7_0: res = 5'h17;
      `ACL_OFF_ETYPE_HIGH: res = 5'h18;
      `ACL_OFF_ETYPE_LOW: res = 5'h19;
      `ACL_OFF_PRIO_ACTION: res = 5'h1a;
      `ACL_OFF_REMARK_MAP: res = 5'h1b;
      `ACL_OFF_SPARE: res = 5'h1c;
      `ACL_OFF_FWD_MAP: res = 5'h1d;
      `ACL_OFF_RULESET_HIGH: res = 5'h1e;
      `ACL_OFF_RULESET_LOW: res = 5'h1f;
      default: res = 5'h00;
    endcase
    return res;
  endfunction : stage_lookup

  // Select bit j of {high, low} covers staging offset 15 - j
  function automatic logic byte_selected(input logic [15:0] sel, input int unsigned k);
    return sel[15 - k];
  endfunction : byte_selected

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  byte_t stage_reg [`ACL_EXT_BYTES:15];
  byte_t sel_high_reg;
  byte_t sel_low_reg;
  xfer_state_t state_reg;
  xfer_state_t state_next;
  logic [INDEX_W-1:0] index_reg;
  logic [15:0] sel_xfer_reg;
  logic read_done_reg;
  logic write_done_reg;
  logic [7:0] rdata_reg;
  logic [3:0] low_load_reg;
  logic [31:0] low_result_reg;
  logic [4:0] wr_hit;
  logic [4:0] rd_hit;
  logic start;
  logic [15:0] mem_byte_en;
  logic [127:0] mem_wdata;
  logic [127:0] mem_rdata;
  logic load_now;
  logic sel_high_hit;
  logic sel_low_hit;
  logic mem_wr;
  logic mem_rd;
  logic [15:0] stage_wr_en;
  logic [15:0] stage_load_en;
  logic [7:0] rdata_next;

  assign wr_hit = stage_lookup(ADDR);
  assign rd_hit = stage_lookup(ADDR);
  assign load_now = (state_reg == ST_LOAD);

  // Exact decode; the port base is stripped before this block
  assign sel_high_hit = (ADDR == `ACL_OFF_SEL_HIGH);
  assign sel_low_hit = (ADDR == `ACL_OFF_SEL_LOW);

  // Table strobes follow the state, so each transfer touches the memory once
  assign mem_wr = (state_reg == ST_WRITE);
  assign mem_rd = (state_reg == ST_READ);

  // Start only when idle; a write during a transfer only stores the byte
  assign start = WR && sel_low_hit && (state_reg == ST_IDLE);

  // Per-byte strobes, kept apart so the load-over-write priority is explicit
  always_comb begin
    stage_wr_en = 16'h0000;
    stage_load_en = 16'h0000;
    for (int k = `ACL_EXT_BYTES; k < 16; k++) begin
      stage_load_en[k] = load_now && byte_selected(sel_xfer_reg, k);
      stage_wr_en[k] = WR && wr_hit[4] && (wr_hit[3:0] == 4'(k));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Staging bytes

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      for (int k = `ACL_EXT_BYTES; k < 16; k++) begin
        stage_reg[k] <= `ACL_RESET_BYTE;
      end
    end else begin
      for (int k = `ACL_EXT_BYTES; k < 16; k++) begin
        // Table results win over a software write in the same cycle
        if (stage_load_en[k]) begin
          stage_reg[k] <= mem_rdata[8*k +: 8];
        end else if (stage_wr_en[k]) begin
          stage_reg[k] <= WDATA;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Byte-select registers
  // Taken even while busy; the running transfer uses its frozen copy

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      sel_high_reg <= `ACL_RESET_BYTE;
    end else if (WR && sel_high_hit) begin
      sel_high_reg <= WDATA;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      sel_low_reg <= `ACL_RESET_BYTE;
    end else if (WR && sel_low_hit) begin
      sel_low_reg <= WDATA;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transfer sequencing
  // A read needs one cycle for the memory and one to load the staging bytes

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (start) begin
          state_next = ACCESS_WRITE ? ST_WRITE : ST_READ;
        end
      end
      ST_WRITE: state_next = ST_IDLE;
      ST_READ: state_next = ST_LOAD;
      ST_LOAD: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Index and select are frozen so later register writes cannot disturb a transfer
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      index_reg <= '0;
      sel_xfer_reg <= 16'h0000;
    end else if (start) begin
      index_reg <= ACCESS_INDEX;
      sel_xfer_reg <= {sel_high_reg, WDATA};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Completion flags
  // Start needs the idle state, so it never meets a completion in one cycle

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      read_done_reg <= `ACL_RESET_DONE;
    end else if (load_now) begin
      read_done_reg <= 1'b1;
    end else if (start && !ACCESS_WRITE) begin
      read_done_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      write_done_reg <= `ACL_RESET_DONE;
    end else if (mem_wr) begin
      write_done_reg <= 1'b1;
    end else if (start && ACCESS_WRITE) begin
      write_done_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Table storage
  // Write data: bytes 0..3 come from the neighbour, the rest from staging

  always_comb begin
    for (int k = 0; k < 16; k++) begin
      mem_byte_en[k] = byte_selected(sel_xfer_reg, k);
      if (k < `ACL_EXT_BYTES) begin
        mem_wdata[8*k +: 8] = LOW_STAGE_DATA[8*k +: 8];
      end else begin
        mem_wdata[8*k +: 8] = stage_reg[k];
      end
    end
  end

  acl_table_mem #(
    .DEPTH(TABLE_DEPTH),
    .IDX_W(INDEX_W)
  ) u_table (
    .clk(CLK),
    .rst(RESET),
    .wr_en(mem_wr),
    .rd_en(mem_rd),
    .index(index_reg),
    .byte_wr_en(mem_byte_en),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  // Bytes 0..3 live next door; hand them their results with a load strobe
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      low_load_reg <= 4'h0;
      low_result_reg <= 32'h0000_0000;
    end else begin
      for (int k = 0; k < `ACL_EXT_BYTES; k++) begin
        low_load_reg[k] <= load_now && byte_selected(sel_xfer_reg, k);
      end
      if (load_now) begin
        low_result_reg <= mem_rdata[31:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register read port

  // Unmapped addresses read as zero
  always_comb begin
    rdata_next = 8'h00;
    if (rd_hit[4]) begin
      rdata_next = stage_reg[rd_hit[3:0]];
    end else if (sel_high_hit) begin
      rdata_next = sel_high_reg;
    end else if (sel_low_hit) begin
      rdata_next = sel_low_reg;
    end
  end

  // Registered, so the data stand in the cycle after the strobe
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      rdata_reg <= 8'h00;
    end else if (RD) begin
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign RDATA = rdata_reg;
  assign READ_DONE = read_done_reg;
  assign WRITE_DONE = write_done_reg;
  assign TRANSFER_BUSY = (state_reg != ST_IDLE);
  assign LOW_STAGE_LOAD = low_load_reg;
  assign LOW_STAGE_RESULT = low_result_reg;

  // Multi-byte values: the lower offset holds the more significant byte
  assign MAC_LOW = {stage_reg[4], stage_reg[5], stage_reg[6], stage_reg[7]};
  assign ETHERTYPE = {stage_reg[8], stage_reg[9]};

  // Action byte at offset ten
  assign PRIORITY_SELECT_MODE =
    stage_reg[10][`ACL_PRIO_MODE_MSB:`ACL_PRIO_MODE_LSB];
  assign PRIORITY = stage_reg[10][`ACL_PRIO_MSB:`ACL_PRIO_LSB];
  assign REMARK_ENABLE_FLAG = stage_reg[10][`ACL_REMARK_EN_BIT];

  // Remark priority straddles offsets ten and eleven
  assign REMARK_PRIORITY = {stage_reg[10][`ACL_REMARK_HI_MSB:`ACL_REMARK_HI_LSB],
                            stage_reg[11][`ACL_REMARK_LO_BIT]};
  assign FORWARD_MAP_MODE =
    stage_reg[11][`ACL_MAP_MODE_MSB:`ACL_MAP_MODE_LSB];

  // Port 5 sits at bit 6, leaving a gap above port 4
  assign FORWARD_PORTS = {stage_reg[13][`ACL_FWD_P5_BIT],
                          stage_reg[13][`ACL_FWD_P1_P4_MSB:0]};

  assign RULESET = {stage_reg[14], stage_reg[15]};

endmodule : acl_entry_staging_regs

/* File: verif/acl_entry_staging_regs_chk.sv */
module acl_entry_staging_regs_chk
  import acl_staging_pkg::*;
#(
  parameter int TABLE_DEPTH = 16,
  parameter int INDEX_W = 4
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // Register port
  input wire logic [15:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  // Transfer
  input wire logic ACCESS_WRITE,
  input wire logic READ_DONE,
  input wire logic WRITE_DONE,
  input wire logic TRANSFER_BUSY,
  input wire logic [3:0] LOW_STAGE_LOAD,
  // Fields
  input wire logic [1:0] PRIORITY_SELECT_MODE,
  input wire logic [2:0] PRIORITY,
  input wire logic REMARK_ENABLE_FLAG,
  input wire logic [2:0] REMARK_PRIORITY,
  input wire logic [1:0] FORWARD_MAP_MODE,
  input wire logic [4:0] FORWARD_PORTS
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  logic [7:0] sel_hi_reg;
  logic [7:0] wd_reg;
  logic start_go;
  logic quiet_wr;
  logic [3:0] load_exp;
  assign start_go = WR && ADDR == 16'h0611 && !TRANSFER_BUSY;
  assign quiet_wr = WR && !TRANSFER_BUSY;
  assign load_exp = {sel_hi_reg[4], sel_hi_reg[5], sel_hi_reg[6], sel_hi_reg[7]};
  // Mirror of the high select, to predict which low bytes get a load pulse
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      sel_hi_reg <= 8'h00;
    end else if (WR && ADDR == 16'h0610) begin
      sel_hi_reg <= WDATA;
    end
  end
  always_ff @(posedge CLK) begin
    wd_reg <= WDATA;
  end
  sequence s_start_rd;
    start_go && !ACCESS_WRITE;
  endsequence
  sequence s_start_wr;
    start_go && ACCESS_WRITE;
  endsequence
  sequence s_rd_wait;
    (!READ_DONE && TRANSFER_BUSY) [*2];
  endsequence
  chk_read_status_seq: assert property (
    s_start_rd |=> s_rd_wait ##1 (READ_DONE && !TRANSFER_BUSY))
    else $error("read status sequence wrong");
  chk_write_dir_seq: assert property (
    s_start_wr |=> (!WRITE_DONE && TRANSFER_BUSY) ##1 (WRITE_DONE && !TRANSFER_BUSY))
    else $error("write status sequence wrong");
  chk_load_pulse_map: assert property (
    s_start_rd |-> ##3 (LOW_STAGE_LOAD == $past(load_exp, 3)))
    else $error("load pulse does not follow high select");
  chk_load_one_cycle: assert property (
    LOW_STAGE_LOAD != 4'h0 |=> LOW_STAGE_LOAD == 4'h0)
    else $error("load pulse longer than one cycle");
  chk_high_no_start: assert property (
    quiet_wr && ADDR == 16'h0610 |=> !TRANSFER_BUSY)
    else $error("high select write started a transfer");
  chk_prio_field_map: assert property (
    quiet_wr && ADDR == 16'h060a |=>
      {PRIORITY_SELECT_MODE, PRIORITY, REMARK_ENABLE_FLAG, REMARK_PRIORITY[2:1]} == wd_reg)
    else $error("priority byte fields wrong");
  chk_remark_low_bit: assert property (
    quiet_wr && ADDR == 16'h060b |=> {REMARK_PRIORITY[0], FORWARD_MAP_MODE} == wd_reg[7:5])
    else $error("remark low bit or map mode wrong");
  chk_fwd_port_bits: assert property (
    quiet_wr && ADDR == 16'h060d |=> FORWARD_PORTS == {wd_reg[6], wd_reg[3:0]})
    else $error("forward port bits wrong");
endmodule : acl_entry_staging_regs_chk

bind acl_entry_staging_regs acl_entry_staging_regs_chk #(
  .TABLE_DEPTH(TABLE_DEPTH), .INDEX_W(INDEX_W)
) u_chk (
  .CLK(CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .ACCESS_WRITE(ACCESS_WRITE), .READ_DONE(READ_DONE), .WRITE_DONE(WRITE_DONE),
  .TRANSFER_BUSY(TRANSFER_BUSY), .LOW_STAGE_LOAD(LOW_STAGE_LOAD),
  .PRIORITY_SELECT_MODE(PRIORITY_SELECT_MODE), .PRIORITY(PRIORITY),
  .REMARK_ENABLE_FLAG(REMARK_ENABLE_FLAG), .REMARK_PRIORITY(REMARK_PRIORITY),
  .FORWARD_MAP_MODE(FORWARD_MAP_MODE), .FORWARD_PORTS(FORWARD_PORTS)
);

/* File: verif/acl_entry_staging_regs_tb.sv */
module acl_entry_staging_regs_tb
  import acl_staging_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK, RESET, WR, RD, ACCESS_WRITE, READ_DONE, WRITE_DONE, TRANSFER_BUSY;
  logic REMARK_ENABLE_FLAG;
  logic [15:0] ADDR, ETHERTYPE, RULESET;
  logic [7:0] WDATA, RDATA;
  logic [3:0] ACCESS_INDEX, LOW_STAGE_LOAD;
  logic [31:0] LOW_STAGE_DATA, LOW_STAGE_RESULT, MAC_LOW;
  logic [1:0] PRIORITY_SELECT_MODE, FORWARD_MAP_MODE;
  logic [2:0] PRIORITY, REMARK_PRIORITY;
  logic [4:0] FORWARD_PORTS;
  byte_t stage_m [18];
  byte_t tbl_m [16];
  int error_cnt = 0;
  int check_count = 0;

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  acl_entry_staging_regs u_acl_entry_staging_regs (
    .CLK(CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .ACCESS_WRITE(ACCESS_WRITE), .ACCESS_INDEX(ACCESS_INDEX), .READ_DONE(READ_DONE),
    .WRITE_DONE(WRITE_DONE), .TRANSFER_BUSY(TRANSFER_BUSY), .LOW_STAGE_DATA(LOW_STAGE_DATA),
    .LOW_STAGE_LOAD(LOW_STAGE_LOAD), .LOW_STAGE_RESULT(LOW_STAGE_RESULT), .MAC_LOW(MAC_LOW),
    .ETHERTYPE(ETHERTYPE), .PRIORITY_SELECT_MODE(PRIORITY_SELECT_MODE), .PRIORITY(PRIORITY),
    .REMARK_ENABLE_FLAG(REMARK_ENABLE_FLAG), .REMARK_PRIORITY(REMARK_PRIORITY),
    .FORWARD_MAP_MODE(FORWARD_MAP_MODE), .FORWARD_PORTS(FORWARD_PORTS), .RULESET(RULESET)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  task automatic wr(input logic [15:0] a, input byte_t d);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr

  // Data is taken only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, output byte_t d);
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    d = RDATA;
  endtask : rd

  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      @(posedge CLK);
      #1;
      n++;
    end while (TRANSFER_BUSY !== 1'b0 && n < 20);
    if (TRANSFER_BUSY !== 1'b0) begin
      error_cnt++;
      $display("FAIL busy expected 0 seen %b", TRANSFER_BUSY);
      finish_test();
    end
  endtask : wait_idle

  task automatic fill();
    byte_t d;
    for (int a = 4; a < 16; a++) begin
      d = byte_t'($urandom);
      wr(16'h0600 + 16'(a), d);
      stage_m[a] = d;
    end
  endtask : fill

  // Sweeps one unmapped address on each side of the window
  task automatic check_all();
    byte_t d;
    for (int a = 3; a < 19; a++) begin
      rd(16'h0600 + 16'(a), d);
      chk($sformatf("reg %h", a), d, (a > 3 && a < 18) ? stage_m[a] : 8'h00);
    end
    chk("mac", MAC_LOW, {stage_m[4], stage_m[5], stage_m[6], stage_m[7]});
    chk("ethertype", ETHERTYPE, {stage_m[8], stage_m[9]});
    chk("prio mode", PRIORITY_SELECT_MODE, stage_m[10][7:6]);
    chk("prio", PRIORITY, stage_m[10][5:3]);
    chk("remark en", REMARK_ENABLE_FLAG, stage_m[10][2]);
    chk("remark", REMARK_PRIORITY, {stage_m[10][1:0], stage_m[11][7]});
    chk("map mode", FORWARD_MAP_MODE, stage_m[11][6:5]);
    chk("fwd ports", FORWARD_PORTS, {stage_m[13][6], stage_m[13][3:0]});
    chk("ruleset", RULESET, {stage_m[14], stage_m[15]});
  endtask : check_all

  function automatic logic [3:0] load_exp(input logic [15:0] sel);
    return {sel[12], sel[13], sel[14], sel[15]};
  endfunction : load_exp

  task automatic xfer(input logic dir, input logic [15:0] sel);
    logic [31:0] low;
    low = $urandom;
    @(posedge CLK);
    ACCESS_WRITE <= dir;
    LOW_STAGE_DATA <= low;
    wr(16'h0610, sel[15:8]);
    wr(16'h0611, sel[7:0]);
    stage_m[16] = sel[15:8];
    stage_m[17] = sel[7:0];
    wait_idle();
    for (int o = 0; o < 16; o++) begin
      if (sel[15 - o] && dir) begin
        tbl_m[o] = (o < 4) ? low[8*o +: 8] : stage_m[o];
      end else if (sel[15 - o] && o > 3) begin
        stage_m[o] = tbl_m[o];
      end
    end
    chk("done", dir ? WRITE_DONE : READ_DONE, 1'b1);
    // The load pulse stands in the cycle in which the read status returns
    if (!dir) begin
      chk("load pulse", LOW_STAGE_LOAD, load_exp(sel));
      for (int o = 0; o < 4; o++) begin
        if (sel[15 - o]) begin
          chk("low result", LOW_STAGE_RESULT[8*o +: 8], tbl_m[o]);
        end
      end
    end
  endtask : xfer

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    RESET = 1'b1;
    WR = 1'b0;
    RD = 1'b0;
    ADDR = 16'h0000;
    WDATA = 8'h00;
    ACCESS_WRITE = 1'b0;
    ACCESS_INDEX = 4'h0;
    LOW_STAGE_DATA = 32'h0000_0000;
    foreach (stage_m[i]) stage_m[i] = 8'h00;
    void'($urandom(29623));
    repeat (5) @(posedge CLK);
    RESET <= 1'b0;
    check_all();
    chk("rdone rst", READ_DONE, 1'b1);
    chk("wdone rst", WRITE_DONE, 1'b1);
    $display("test reset values done");
    fill();
    check_all();
    $display("test register access done");
    ACCESS_INDEX <= 4'($urandom);
    // First write fills the whole entry so later partial reads see known bytes
    for (int i = 0; i < 6; i++) begin
      fill();
      xfer(1'b1, (i == 0) ? 16'hffff : 16'($urandom));
      fill();
      xfer(1'b0, (i == 1) ? 16'h0000 : (i == 2) ? 16'h8001 : 16'($urandom));
      check_all();
    end
    $display("test table transfers done");
    // Select write while a read is busy is stored but starts nothing
    ACCESS_WRITE <= 1'b0;
    wr(16'h0610, 8'h00);
    wr(16'h0611, 8'h00);
    wr(16'h0611, 8'h5a);
    #1;
    chk("refused start", TRANSFER_BUSY, 1'b0);
    stage_m[16] = 8'h00;
    stage_m[17] = 8'h5a;
    check_all();
    $display("test refused start done");
    finish_test();
  end
endmodule : acl_entry_staging_regs_tb
